// >>> rtl/csf_flag_unit.sv
// Result and flag computation for one core operation, purely combinational.
// Assumes the caller has already chosen the file operand.
`timescale 1ns/1ps
module csf_flag_unit import csf_pkg::*; (
    // Operation and operands
    input wire csf_op_t op,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] w_data,
    input wire logic [7:0] f_data,
    input wire logic carry_in,
    // Result with flags
    output csf_alu_t alu
);

    // ************************************************************
    // Adder shared by add and subtract
    // ************************************************************
    // Subtract adds the inverted operand plus one, so carry means no borrow
    wire is_sub = (op == CSF_SUB);
    wire [7:0] addend = is_sub ? ~w_data : w_data;
    wire [8:0] sum = {1'b0, f_data} + {1'b0, addend} + {8'h00, is_sub};
    wire [4:0] nib_sum = {1'b0, f_data[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
    wire [7:0] bit_one = 8'h01 << bit_sel;

    // Result select and flag outputs
    always_comb begin
        alu.result = f_data;
        alu.carry = carry_in;
        alu.nib = nib_sum[4];
        case (op)
            CSF_ADD, CSF_SUB: begin
                alu.result = sum[7:0];
                alu.carry = sum[8];
            end
            CSF_AND: alu.result = f_data & w_data;
            CSF_IOR: alu.result = f_data | w_data;
            CSF_XOR: alu.result = f_data ^ w_data;
            CSF_ROTL: begin
                alu.result = {f_data[6:0], carry_in};
                alu.carry = f_data[7];
            end
            CSF_ROTR: begin
                alu.result = {carry_in, f_data[7:1]};
                alu.carry = f_data[0];
            end
            CSF_CLR: alu.result = 8'h00;
            CSF_MOVE: alu.result = w_data;
            CSF_SWAP: alu.result = {f_data[3:0], f_data[7:4]};
            CSF_BCLR: alu.result = f_data & ~bit_one;
            CSF_BSET: alu.result = f_data | bit_one;
            default: alu.result = f_data;
        endcase
        alu.zero = (alu.result == 8'h00);
    end

endmodule

// >>> rtl/csf_pkg.sv
// Shared constants, types and helpers for the processor status flag block.
// Assumes one 50 MHz clock and a word-indexed Avalon-MM register port.
package csf_pkg;

    // ************************************************************
    // Clock and register addressing
    // ************************************************************
    localparam int CLK_MHZ = 50;
    localparam int ADDR_W = 9;
    localparam int BANK_OFS_W = 7;
    localparam logic [ADDR_W-1:0] STATUS_IDX = 9'h003;
    localparam logic [ADDR_W-1:0] STATUS_IDX_B1 = 9'h083;
    localparam logic [ADDR_W-1:0] STATUS_IDX_B2 = 9'h103;
    localparam logic [ADDR_W-1:0] STATUS_IDX_B3 = 9'h183;
    localparam logic [ADDR_W-1:0] OPTION_IDX = 9'h081;
    localparam logic [ADDR_W-1:0] OPTION_IDX_B3 = 9'h181;
    localparam int OPTION_BANK_BIT = 7;

    // ************************************************************
    // Status register fields and reset values
    // ************************************************************
    localparam int ST_IND_BANK = 7;
    localparam int ST_DIR_HI = 6;
    localparam int ST_DIR_LO = 5;
    localparam int ST_WDOG_EXP = 4;
    localparam int ST_SLEEP = 3;
    localparam int ST_ZERO = 2;
    localparam int ST_NIB = 1;
    localparam int ST_CARRY = 0;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] STATUS_RO_MASK = 8'h18;
    localparam logic [7:0] STATUS_ALU_MASK = 8'h07;
    localparam logic [7:0] STATUS_BANK_KEEP = 8'h1F;

    // ************************************************************
    // Timer option register fields
    // ************************************************************
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam int OPT_ASSIGN = 3;
    localparam int OPT_RATE_LSB = 0;
    localparam int OPT_RATE_W = 3;
    localparam int PRESC_W = 8;
    localparam logic [3:0] PRESC_FULL = 4'h8;

    // ************************************************************
    // Core operations and carriers
    // ************************************************************
    typedef enum logic [3:0] {
        CSF_ADD, CSF_SUB, CSF_AND, CSF_IOR, CSF_XOR, CSF_ROTL, CSF_ROTR,
        CSF_CLR, CSF_MOVE, CSF_SWAP, CSF_BCLR, CSF_BSET
    } csf_op_t;

    typedef struct packed {
        logic valid;
        csf_op_t op;
        logic dest_status;
        logic [2:0] bit_sel;
        logic [7:0] w_data;
        logic [7:0] f_data;
    } csf_core_req_t;

    typedef struct packed {
        logic [7:0] result;
        logic zero;
        logic nib;
        logic carry;
    } csf_alu_t;

    typedef struct packed {
        logic valid;
        logic [7:0] result;
    } csf_core_res_t;

    // Which of zero, nibble and carry flags an operation updates
    function automatic logic [2:0] csf_flag_mask(input csf_op_t op);
        case (op)
            CSF_ADD, CSF_SUB: csf_flag_mask = 3'h7;
            CSF_AND, CSF_IOR, CSF_XOR, CSF_CLR: csf_flag_mask = 3'h4;
            CSF_ROTL, CSF_ROTR: csf_flag_mask = 3'h1;
            default: csf_flag_mask = 3'h0;
        endcase
    endfunction

endpackage

// >>> rtl/csf_status_block.sv
// Processor status flag register, timer option register and shared prescaler.
// Assumes the core presents at most one operation per cycle and that
// software reaches both registers over a word-indexed Avalon-MM port.
`timescale 1ns/1ps

module csf_status_block import csf_pkg::*; #(
    parameter int DATA_W = 32
) (
    // Clock and power-up reset
    input wire logic mclk,
    input wire logic resetn,
    // Avalon-MM register slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [DATA_W/8-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Core operation port
    input wire csf_core_req_t core_req,
    output csf_core_res_t core_res,
    // Reset cause events, one-cycle pulses
    input wire logic ext_reset_pulse,
    input wire logic wdog_timeout_pulse,
    input wire logic wdog_clear_pulse,
    input wire logic sleep_pulse,
    // Bank addressing
    input wire logic [BANK_OFS_W-1:0] direct_offset,
    input wire logic [7:0] indirect_pointer,
    output logic [ADDR_W-1:0] direct_addr,
    output logic [ADDR_W-1:0] indirect_addr,
    // Prescaler ticks and outputs
    input wire logic timer_tick,
    input wire logic wdog_tick,
    output logic timer_inc,
    output logic wdog_post
);

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] status_reg, status_next;
    logic [7:0] option_reg, option_next;
    logic served_reg;
    logic [DATA_W-1:0] readdata_reg;
    csf_core_res_t core_res_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic timer_inc_reg, wdog_post_reg;
    csf_alu_t alu;

    // ************************************************************
    // Register decode, status mirrored in every bank, option only where address bit 7 is set
    // ************************************************************
    wire [BANK_OFS_W-1:0] bank_ofs = avs_address[BANK_OFS_W-1:0];
    wire sel_status = (bank_ofs == STATUS_IDX[BANK_OFS_W-1:0]);
    wire sel_option = (bank_ofs == OPTION_IDX[BANK_OFS_W-1:0])
        && avs_address[OPTION_BANK_BIT];
    wire bus_req = avs_read | avs_write;
    wire core_fire = core_req.valid;
    // Core has priority; a bus access waits out a core update
    wire bus_done = bus_req & served_reg & ~core_fire;
    wire bus_wr = bus_done & avs_write & avs_byteenable[0];
    wire wr_status = bus_wr & sel_status;
    wire wr_option = bus_wr & sel_option;
    wire [7:0] wdata8 = avs_writedata[7:0];
    // Unmapped words and upper bits read zero
    wire [7:0] rd_byte = sel_status ? status_reg : sel_option ? option_reg : 8'h00;
    wire [DATA_W-1:0] rd_word = {{(DATA_W-8){1'b0}}, rd_byte};

    // Handshake: one wait cycle, longer while any core operation is valid
    assign avs_waitrequest = bus_req & ~bus_done;
    assign avs_readdata = readdata_reg;

    // ************************************************************
    // Core operation and flag merge
    // ************************************************************
    // Operations on the status register act on its live value
    wire [7:0] f_eff = core_req.dest_status ? status_reg : core_req.f_data;
    wire [2:0] fmask = csf_flag_mask(core_req.op);
    wire alu_op = |fmask;
    wire [7:0] keep_mask = STATUS_RO_MASK | (alu_op ? STATUS_ALU_MASK : 8'h00);
    wire [7:0] flag_bits = {5'h00, alu.zero, alu.nib, alu.carry};
    wire [7:0] flag_sel = {5'h00, fmask};
    wire nonpor = ext_reset_pulse | wdog_timeout_pulse;

    csf_flag_unit u_flag (
        .op(core_req.op),
        .bit_sel(core_req.bit_sel),
        .w_data(core_req.w_data),
        .f_data(f_eff),
        .carry_in(status_reg[ST_CARRY]),
        .alu(alu)
    );

    // Next status value: write, flags, then reset-cause events
    always_comb begin
        status_next = status_reg;
        if (core_fire && core_req.dest_status) begin
            // Flag-writing ops block the data write to the low three bits
            status_next = (alu.result & ~keep_mask) | (status_reg & keep_mask);
        end else if (wr_status) begin
            status_next = (wdata8 & ~STATUS_RO_MASK) | (status_reg & STATUS_RO_MASK);
        end
        if (core_fire) begin
            // Clear gives zero flag set, other flags untouched
            status_next = (status_next & ~flag_sel) | (flag_bits & flag_sel);
        end
        if (nonpor) begin
            status_next = status_next & STATUS_BANK_KEEP;
        end
        if (wdog_timeout_pulse) begin
            status_next[ST_WDOG_EXP] = 1'b0;
        end
        // Clear and sleep sets win over a timeout in the same cycle
        if (wdog_clear_pulse) begin
            status_next[ST_WDOG_EXP] = 1'b1;
            status_next[ST_SLEEP] = 1'b1;
        end
        if (sleep_pulse) begin
            status_next[ST_WDOG_EXP] = 1'b1;
            status_next[ST_SLEEP] = 1'b0;
        end
    end

    // Option register: software write, preset on any reset
    always_comb begin
        option_next = option_reg;
        if (wr_option) begin
            option_next = wdata8;
        end
        if (nonpor) begin
            option_next = OPTION_RST;
        end
    end

    // Register update; resetn is the power-up reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status_reg <= STATUS_POR;
            option_reg <= OPTION_RST;
        end else begin
            status_reg <= status_next;
            option_reg <= option_next;
        end
    end

    // Bus handshake and read capture
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            served_reg <= 1'b0;
            readdata_reg <= '0;
        end else begin
            served_reg <= bus_req & ~bus_done;
            if (avs_read && !bus_done) begin
                readdata_reg <= rd_word;
            end
        end
    end

    // Result back to the core, one cycle after the operation
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            core_res_reg <= '0;
        end else begin
            core_res_reg.valid <= core_fire;
            core_res_reg.result <= alu.result;
        end
    end
    assign core_res = core_res_reg;

    // ************************************************************
    // Bank addressing
    // ************************************************************
    // Direct bank by binary value, indirect pair by the high bit
    assign direct_addr = {status_reg[ST_DIR_HI:ST_DIR_LO], direct_offset};
    assign indirect_addr = {status_reg[ST_IND_BANK], indirect_pointer};

    // ************************************************************
    // Shared prescaler
    // ************************************************************
    // Mask of the low n counter bits; n of zero gives a 1:1 rate
    function automatic logic [PRESC_W-1:0] presc_mask(input logic [3:0] n);
        presc_mask = 8'hFF >> (PRESC_FULL - n);
    endfunction

    wire to_wdog = option_reg[OPT_ASSIGN];
    wire [OPT_RATE_W-1:0] rate = option_reg[OPT_RATE_LSB +: OPT_RATE_W];
    wire [PRESC_W-1:0] tmr_mask = presc_mask({1'b0, rate} + 4'h1);
    wire [PRESC_W-1:0] wd_mask = presc_mask({1'b0, rate});
    wire presc_tick = to_wdog ? wdog_tick : timer_tick;
    wire tmr_hit = (presc_reg & tmr_mask) == tmr_mask;
    wire wd_hit = (presc_reg & wd_mask) == wd_mask;
    // Unassigned side runs straight through at 1:1
    wire timer_inc_next = to_wdog ? timer_tick : (timer_tick & tmr_hit);
    wire wdog_post_next = to_wdog ? (wdog_tick & wd_hit) : wdog_tick;

    // Prescaler count and registered tick outputs
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            presc_reg <= '0;
            timer_inc_reg <= 1'b0;
            wdog_post_reg <= 1'b0;
        end else begin
            if (wr_option || nonpor) begin
                // Restart so a new rate never fires early
                presc_reg <= '0;
            end else if (presc_tick) begin
                presc_reg <= presc_reg + 8'h01;
            end
            timer_inc_reg <= timer_inc_next;
            wdog_post_reg <= wdog_post_next;
        end
    end
    assign timer_inc = timer_inc_reg;
    assign wdog_post = wdog_post_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    wire quiet = ~nonpor & ~wdog_clear_pulse & ~sleep_pulse;

    sequence s_sw_status_write;
        wr_status && !core_fire && quiet;
    endsequence

    sequence s_core_on_status(csf_op_t k);
        core_fire && core_req.dest_status && core_req.op == k && quiet;
    endsequence

    property p_ro_flags;
        @(posedge mclk) disable iff (!resetn)
        s_sw_status_write |=> status_reg[ST_WDOG_EXP:ST_SLEEP] ==
            $past(status_reg[ST_WDOG_EXP:ST_SLEEP]);
    endproperty
    a_ro_flags: assert property (p_ro_flags) else $error("reset-cause flag written");

    property p_alu_override;
        @(posedge mclk) disable iff (!resetn)
        s_core_on_status(CSF_ADD) |=> status_reg[ST_ZERO:ST_CARRY] ==
            $past({alu.zero, alu.nib, alu.carry});
    endproperty
    a_alu_override: assert property (p_alu_override) else $error("flags not from result");

    property p_clear_status;
        @(posedge mclk) disable iff (!resetn)
        s_core_on_status(CSF_CLR) |=> status_reg[7:5] == 3'h0 && status_reg[ST_ZERO]
            && status_reg[4:0] == ($past(status_reg[4:0]) | 5'h04);
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("clear result wrong");

    property p_plain_ops;
        @(posedge mclk) disable iff (!resetn)
        core_fire && (core_req.op inside {CSF_BCLR, CSF_BSET, CSF_SWAP, CSF_MOVE})
            && !core_req.dest_status && quiet
            |=> status_reg == $past(status_reg);
    endproperty
    a_plain_ops: assert property (p_plain_ops) else $error("bit op touched flags");

    property p_sub_no_borrow;
        @(posedge mclk) disable iff (!resetn)
        core_fire && core_req.op == CSF_SUB && !core_req.dest_status && quiet
            && core_req.f_data == core_req.w_data
            |=> status_reg[ST_ZERO:ST_CARRY] == 3'h7;
    endproperty
    a_sub_no_borrow: assert property (p_sub_no_borrow) else $error("borrow sense wrong");

    property p_rotl_carry;
        @(posedge mclk) disable iff (!resetn)
        core_fire && core_req.op == CSF_ROTL && !core_req.dest_status && quiet
            |=> status_reg[ST_CARRY] == $past(core_req.f_data[7]);
    endproperty
    a_rotl_carry: assert property (p_rotl_carry) else $error("rotate carry wrong");

    property p_unmapped_zero;
        @(posedge mclk) disable iff (!resetn)
        avs_read && !avs_waitrequest && !sel_status && !sel_option |-> avs_readdata == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_nonpor;
        @(posedge mclk) disable iff (!resetn)
        nonpor |=> status_reg[7:5] == 3'h0 && option_reg == OPTION_RST;
    endproperty
    a_nonpor: assert property (p_nonpor) else $error("other reset values wrong");

    property p_wdog_passthru;
        @(posedge mclk) disable iff (!resetn)
        !to_wdog ##1 1'b1 |-> wdog_post == $past(wdog_tick);
    endproperty
    a_wdog_passthru: assert property (p_wdog_passthru) else $error("watchdog not 1:1");

    property p_sleep_flags;
        @(posedge mclk) disable iff (!resetn)
        sleep_pulse && !wdog_clear_pulse |=> status_reg[ST_WDOG_EXP] && !status_reg[ST_SLEEP];
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_mirror;
        @(posedge mclk) disable iff (!resetn)
        avs_read && !avs_waitrequest && avs_address == STATUS_IDX_B3
            && $past(avs_read) && !$past(core_fire) && $past(quiet)
            |-> avs_readdata[7:0] == status_reg;
    endproperty
    a_mirror: assert property (p_mirror) else $error("status not mirrored");

    property p_rotr_carry;
        @(posedge mclk) disable iff (!resetn)
        core_fire && core_req.op == CSF_ROTR && !core_req.dest_status && quiet
            |=> status_reg[ST_CARRY] == $past(core_req.f_data[0]);
    endproperty
    a_rotr_carry: assert property (p_rotr_carry) else $error("rotr carry wrong");

    // Difference is independent of how the adder forms it
    property p_sub_result;
        @(posedge mclk) disable iff (!resetn)
        core_fire && core_req.op == CSF_SUB && !core_req.dest_status |=> core_res.valid
            && core_res.result == 8'($past(core_req.f_data) - $past(core_req.w_data));
    endproperty
    a_sub_result: assert property (p_sub_result) else $error("difference wrong");

    property p_tmo_flag;
        @(posedge mclk) disable iff (!resetn)
        wdog_timeout_pulse && !wdog_clear_pulse && !sleep_pulse |=> !status_reg[ST_WDOG_EXP];
    endproperty
    a_tmo_flag: assert property (p_tmo_flag) else $error("expiry not cleared");

    // A new rate or a non-power-up reset starts the shared count afresh
    property p_presc_clr;
        @(posedge mclk) disable iff (!resetn)
        wr_option || nonpor |=> presc_reg == '0;
    endproperty
    a_presc_clr: assert property (p_presc_clr) else $error("prescaler kept count");

endmodule

// >>> tb/cpu_status_flag_register_bench.sv
// Self-checking bench for the status flag block: bus, core ops, events.
// Assumes the core model drives the operation port.
`timescale 1ns/1ps
module cpu_status_flag_register_bench import csf_pkg::*;;
    logic mclk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [ADDR_W-1:0] avs_address = 9'h000;
    logic [ADDR_W-1:0] direct_addr, indirect_addr;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h4A, r;
    logic [3:0] avs_byteenable = 4'hF, evt = 4'h0;
    logic avs_waitrequest, timer_tick = 1'b0, wdog_tick = 1'b0, timer_inc, wdog_post;
    logic [BANK_OFS_W-1:0] direct_offset = 7'h00;
    logic [7:0] indirect_pointer = 8'h00, st;
    csf_core_req_t core_req;
    csf_core_res_t core_res;
    int n_fail = 0, checks = 0, n_ti = 0, n_wp = 0;

    // ********************
    // Harness
    // ********************
    always #10 mclk = ~mclk;
    csf_status_block dut_u (.mclk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .core_req,
        .core_res, .ext_reset_pulse(evt[3]), .wdog_timeout_pulse(evt[2]),
        .wdog_clear_pulse(evt[1]), .sleep_pulse(evt[0]), .direct_offset,
        .indirect_pointer, .direct_addr, .indirect_addr, .timer_tick, .wdog_tick,
        .timer_inc, .wdog_post);
    csf_core_model core_u (.mclk, .core_req);
    // Pulses sampled mid-cycle, away from the launching edge
    always @(negedge mclk) begin
        if (timer_inc === 1'b1) n_ti++;
        if (wdog_post === 1'b1) n_wp++;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected {result, zero, nibble, carry}; unaffected flags pass through
    function automatic logic [10:0] alu(csf_op_t op, logic [2:0] b, logic [7:0] w,
                                        logic [7:0] f, logic [2:0] fl);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] q;
        logic [2:0] o;
        begin
            o = fl;
            q = f;
            s = {1'b0, f} + {1'b0, ~w} + 9'h001;
            h = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
            if (op == CSF_ADD) begin
                s = {1'b0, f} + {1'b0, w};
                h = {1'b0, f[3:0]} + {1'b0, w[3:0]};
            end
            case (op)
                CSF_ADD, CSF_SUB: begin
                    q = s[7:0];
                    o[1:0] = {h[4], s[8]};
                end
                CSF_AND: q = f & w;
                CSF_IOR: q = f | w;
                CSF_XOR: q = f ^ w;
                CSF_CLR: q = 8'h00;
                CSF_ROTL: {o[0], q} = {f, fl[0]};
                CSF_ROTR: {q, o[0]} = {fl[0], f};
                CSF_MOVE: q = w;
                CSF_SWAP: q = {f[3:0], f[7:4]};
                CSF_BCLR: q = f & ~(8'h01 << b);
                default: q = f | (8'h01 << b);
            endcase
            if (op inside {CSF_ADD, CSF_SUB, CSF_AND, CSF_IOR, CSF_XOR, CSF_CLR})
                o[2] = (q == 8'h00);
            return {q, o};
        end
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Request held until waitrequest is sampled low at a falling edge, then dropped at the next rising edge
    task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d,
                       input logic be, output logic [31:0] q);
        logic w;
        begin
            @(posedge mclk);
            avs_address <= a;
            avs_write <= wr;
            avs_read <= ~wr;
            avs_writedata <= {24'h000000, d};
            avs_byteenable <= {3'h7, be};
            do begin
                @(negedge mclk);
                w = avs_waitrequest;
                q = avs_readdata;
                @(posedge mclk);
            end while (w !== 1'b0);
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 1'b1, q);
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 1'b1, q);
        chk(q, {24'h000000, e});
    endtask
    task automatic op_chk(input csf_op_t op, input logic dest, input logic [31:0] v);
        logic [10:0] e;
        logic upd;
        begin
            e = alu(op, v[2:0], v[15:8], dest ? st : v[23:16], st[2:0]);
            upd = op inside {CSF_ADD, CSF_SUB, CSF_AND, CSF_IOR, CSF_XOR, CSF_CLR,
                             CSF_ROTL, CSF_ROTR};
            direct_offset <= v[30:24];
            indirect_pointer <= v[31:24] ^ v[7:0];
            core_u.issue(op, dest, v[2:0], v[15:8], v[23:16]);
            @(negedge mclk);
            chk({23'h0, core_res}, {24'h1, e[10:3]});
            if (dest)
                st = {e[10:8], st[4:3], upd ? e[2:0] : e[5:3]};
            else
                st[2:0] = e[2:0];
            rd_chk(STATUS_IDX, st);
            chk(direct_addr, {st[6:5], direct_offset});
            chk(indirect_addr, {st[7], indirect_pointer});
        end
    endtask

    // ********************
    // Sequence
    // ********************
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        st = STATUS_POR;
        rd_chk(STATUS_IDX, st);
        rd_chk(OPTION_IDX, OPTION_RST);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            wr({i[1:0], 7'h03}, r[7:0]);
            st = (r[7:0] & ~STATUS_RO_MASK) | (st & STATUS_RO_MASK);
            for (int j = 0; j < 4; j++)
                rd_chk({j[1:0], 7'h03}, st);
        end
        bus(1'b1, STATUS_IDX, ~st, 1'b0, r);
        rd_chk(STATUS_IDX, st);
        wr(9'h005, 8'hA5);
        rd_chk(9'h005, 8'h00);
        wr(OPTION_IDX, 8'h5A);
        rd_chk(OPTION_IDX_B3, 8'h5A);
        op_chk(CSF_CLR, 1'b1, xs());
        op_chk(CSF_SUB, 1'b0, 32'h005A5A00);
        op_chk(CSF_ADD, 1'b1, xs());
        op_chk(CSF_ROTL, 1'b0, xs());
        op_chk(CSF_ROTR, 1'b0, xs());
        for (int i = 0; i < 60; i++)
            op_chk(csf_op_t'(xs() % 12), xs() % 4 == 0, xs());
        // Sleep, clear, timeout, external reset in turn
        for (int k = 0; k < 4; k++) begin
            wr(STATUS_IDX, 8'hE5);
            st = (8'hE5 & ~STATUS_RO_MASK) | (st & STATUS_RO_MASK);
            wr(OPTION_IDX, 8'h00);
            evt[k] <= 1'b1;
            @(posedge mclk);
            evt <= 4'h0;
            case (k)
                0: st[4:3] = 2'b10;
                1: st[4:3] = 2'b11;
                2: st[7:4] = 4'h0;
                default: st[7:5] = 3'h0;
            endcase
            rd_chk(STATUS_IDX, st);
            rd_chk(OPTION_IDX_B3, k > 1 ? 8'hFF : 8'h00);
        end
        // Prescaler on either side, random rate
        for (int i = 0; i < 4; i++) begin
            r = xs();
            wr(i[1] ? OPTION_IDX_B3 : OPTION_IDX, {4'h0, i[0], r[2:0]});
            n_ti = 0;
            n_wp = 0;
            timer_tick <= 1'b1;
            wdog_tick <= 1'b1;
            repeat (64) @(posedge mclk);
            timer_tick <= 1'b0;
            wdog_tick <= 1'b0;
            repeat (2) @(posedge mclk);
            chk(n_ti, i[0] ? 64 : 64 >> (r[2:0] + 1));
            chk(n_wp, i[0] ? 64 >> r[2:0] : 64);
        end
        stop_test;
    end
endmodule

// >>> tb/csf_core_model.sv
// Behavioural processor core that issues one operation per call.
// Assumes the status block samples the request on the rising edge.
`timescale 1ns/1ps
module csf_core_model import csf_pkg::*; (
    // Clock
    input wire logic mclk,
    // Request toward the status block
    output csf_core_req_t core_req
);
    // ********************
    // Issue
    // ********************
    initial begin
        core_req = '0;
    end
    // Valid for one cycle; idle operands flip so stale data never matches
    task automatic issue(input csf_op_t op, input logic dest, input logic [2:0] b,
                         input logic [7:0] w, input logic [7:0] f);
        begin
            @(posedge mclk);
            core_req <= '{1'b1, op, dest, b, w, f};
            @(posedge mclk);
            core_req <= '{1'b0, op, 1'b0, ~b, ~w, ~f};
        end
    endtask
endmodule
